// >>> eiop2_pkg.sv
// Package for the 8-bit I/O port: register map, reset values, fields, modes
package eiop2_pkg;
   localparam int PORT_W = 8;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   // Register indices (printed offsets), byte address is index times four
   localparam logic [ADDR_W-1:0] IDX_SERIAL_PIN_MODE = 16'hFFC9;
   localparam logic [ADDR_W-1:0] IDX_OPEN_DRAIN_SELECT = 16'hFFCB;
   localparam logic [ADDR_W-1:0] IDX_PORT_DATA_LATCH = 16'hFFD5;
   localparam logic [ADDR_W-1:0] IDX_PORT_DIRECTION = 16'hFFE5;
   localparam logic [ADDR_W-1:0] IDX_POWER_MODE = 16'hFFF0;
   localparam logic [ADDR_W+1:0] ADDR_SERIAL_PIN_MODE = {IDX_SERIAL_PIN_MODE, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_OPEN_DRAIN_SELECT = {IDX_OPEN_DRAIN_SELECT, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_PORT_DATA_LATCH = {IDX_PORT_DATA_LATCH, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_PORT_DIRECTION = {IDX_PORT_DIRECTION, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_POWER_MODE = {IDX_POWER_MODE, 2'b00};
   // Reset values
   localparam logic [7:0] RST_SERIAL_PIN_MODE = 8'hD8;
   localparam logic [7:0] RST_OPEN_DRAIN_SELECT = 8'h00;
   localparam logic [7:0] RST_PORT_DATA_LATCH = 8'h00;
   localparam logic [7:0] RST_PORT_DIRECTION = 8'h00;
   localparam logic [7:0] SPM_FIXED_ONES = 8'hD8;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   // Serial pin mode fields
   localparam int SPM_BUF_TYPE_BIT = 5;
   localparam int SPM_DOUT_BIT = 2;
   localparam int SPM_DIN_BIT = 1;
   localparam int SPM_CLK_BIT = 0;
   // Pins owned by the serial channel
   localparam int PIN_SDOUT = 2;
   localparam int PIN_SDIN = 1;
   localparam int PIN_SCLK = 0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Operating modes
   typedef enum logic [2:0] {
      EIOP2_MODE_ACTIVE = 3'h0,
      EIOP2_MODE_SUBACTIVE = 3'h1,
      EIOP2_MODE_SLEEP = 3'h2,
      EIOP2_MODE_SUBSLEEP = 3'h3,
      EIOP2_MODE_WATCH = 3'h4,
      EIOP2_MODE_STANDBY = 3'h5
   } eiop2_mode_e;
   // Write channel state, one-hot
   typedef enum logic [2:0] {
      EIOP2_WR_IDLE = 3'b001,
      EIOP2_WR_HAVE = 3'b010,
      EIOP2_WR_RESP = 3'b100
   } eiop2_wr_e;
endpackage

// >>> eiop2_pin_cell.sv
// One port pin: mux of general I/O and alternate function, drive type, low-power hold
module eiop2_pin_cell (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic alt_sel,
   input wire logic alt_oe,
   input wire logic alt_out,
   input wire logic alt_open_drain,
   input wire logic dir_out,
   input wire logic latch_val,
   input wire logic open_drain,
   input wire logic float_pin,
   input wire logic hold_pin,
   output logic pin_o,
   output logic pin_oe
);
   logic drive, level, od;
   logic out_q, out_d, oe_q, oe_d;

   always_comb begin
      // Alternate function ignores direction and latch
      drive = alt_sel ? alt_oe : dir_out;
      level = alt_sel ? alt_out : latch_val;
      od = alt_sel ? alt_open_drain : open_drain;
      out_d = level;
      // Open drain: only drive low
      oe_d = drive && !(od && level);
      if (hold_pin) begin
         out_d = out_q;
         oe_d = oe_q;
      end
      if (float_pin) begin
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign pin_o = out_q;
   assign pin_oe = oe_q;
endmodule

// >>> eiop2_port.sv
// Top of the 8-bit I/O port with serial pin routing, behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
module eiop2_port
   import eiop2_pkg::*;
#(
   parameter int WIDTH = eiop2_pkg::PORT_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [eiop2_pkg::ADDR_W+1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [eiop2_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [eiop2_pkg::ADDR_W+1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [eiop2_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] pin_o,
   output logic [WIDTH-1:0] pin_oe,
   input wire logic serial_data_out,
   output logic serial_data_in,
   input wire logic serial_clock_out,
   input wire logic serial_clock_oe,
   output logic serial_clock_in
);
   import eiop2_pkg::*;

   logic [WIDTH-1:0] port_data_latch_q, port_data_latch_d;
   logic [WIDTH-1:0] port_direction_q, port_direction_d;
   logic [WIDTH-1:0] open_drain_select_q, open_drain_select_d;
   logic [7:0] serial_pin_mode_q, serial_pin_mode_d;
   eiop2_mode_e power_mode_q, power_mode_d;
   logic [WIDTH-1:0] sync1_q, sync2_q;
   eiop2_wr_e wr_state_q, wr_state_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [ADDR_W+1:0] aw_addr_q, aw_addr_d;
   logic [7:0] w_data_q, w_data_d;
   logic w_strb_q, w_strb_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [WIDTH-1:0] port_read;
   logic [WIDTH-1:0] alt_sel, alt_oe, alt_out;
   logic float_pins, hold_pins;

   function automatic logic addr_known(input logic [ADDR_W+1:0] a);
      addr_known = (a == ADDR_SERIAL_PIN_MODE) || (a == ADDR_OPEN_DRAIN_SELECT) ||
                   (a == ADDR_PORT_DATA_LATCH) || (a == ADDR_PORT_DIRECTION) ||
                   (a == ADDR_POWER_MODE);
   endfunction

   // Pin input synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
      end
   end

   assign port_read = (port_direction_q & port_data_latch_q) | (~port_direction_q & sync2_q);

   // Write channel
   always_comb begin
      wr_state_d = wr_state_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bresp_d = bresp_q;
      port_data_latch_d = port_data_latch_q;
      port_direction_d = port_direction_q;
      open_drain_select_d = open_drain_select_q;
      serial_pin_mode_d = serial_pin_mode_q;
      power_mode_d = power_mode_q;
      unique case (wr_state_q)
         EIOP2_WR_IDLE, EIOP2_WR_HAVE: begin
            if (s_axi_awvalid && !aw_have_q) begin
               aw_have_d = 1'b1;
               aw_addr_d = s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
               w_have_d = 1'b1;
               w_data_d = s_axi_wdata[7:0];
               w_strb_d = s_axi_wstrb[0];
            end
            wr_state_d = (aw_have_d || w_have_d) ? EIOP2_WR_HAVE : EIOP2_WR_IDLE;
            if (aw_have_d && w_have_d) begin
               wr_state_d = EIOP2_WR_RESP;
               aw_have_d = 1'b0;
               w_have_d = 1'b0;
               bresp_d = addr_known(aw_addr_d) ? RESP_OKAY : RESP_SLVERR;
               if (w_strb_d) begin
                  unique case (aw_addr_d)
                     ADDR_PORT_DATA_LATCH: port_data_latch_d = w_data_d;
                     ADDR_PORT_DIRECTION: port_direction_d = w_data_d;
                     ADDR_OPEN_DRAIN_SELECT: open_drain_select_d = w_data_d;
                     ADDR_SERIAL_PIN_MODE: serial_pin_mode_d = w_data_d | SPM_FIXED_ONES;
                     ADDR_POWER_MODE: begin
                        if (w_data_d[2:0] <= EIOP2_MODE_STANDBY) begin
                           power_mode_d = eiop2_mode_e'(w_data_d[2:0]);
                        end
                     end
                     default: ;
                  endcase
               end
            end
         end
         EIOP2_WR_RESP: begin
            if (s_axi_bready) begin
               wr_state_d = EIOP2_WR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= EIOP2_WR_IDLE;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         port_data_latch_q <= RST_PORT_DATA_LATCH;
         port_direction_q <= RST_PORT_DIRECTION;
         open_drain_select_q <= RST_OPEN_DRAIN_SELECT;
         serial_pin_mode_q <= RST_SERIAL_PIN_MODE;
         power_mode_q <= EIOP2_MODE_ACTIVE;
      end else begin
         wr_state_q <= wr_state_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bresp_q <= bresp_d;
         port_data_latch_q <= port_data_latch_d;
         port_direction_q <= port_direction_d;
         open_drain_select_q <= open_drain_select_d;
         serial_pin_mode_q <= serial_pin_mode_d;
         power_mode_q <= power_mode_d;
      end
   end

   assign s_axi_awready = (wr_state_q != EIOP2_WR_RESP) && !aw_have_q;
   assign s_axi_wready = (wr_state_q != EIOP2_WR_RESP) && !w_have_q;
   assign s_axi_bvalid = (wr_state_q == EIOP2_WR_RESP);
   assign s_axi_bresp = bresp_q;

   // Read channel
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (!rvalid_q && s_axi_arvalid) begin
         rvalid_d = 1'b1;
         rresp_d = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_d = '0;
         unique case (s_axi_araddr)
            ADDR_PORT_DATA_LATCH: rdata_d[7:0] = port_read;
            ADDR_PORT_DIRECTION: rdata_d[7:0] = ALL_ONES;
            ADDR_OPEN_DRAIN_SELECT: rdata_d[7:0] = open_drain_select_q;
            ADDR_SERIAL_PIN_MODE: rdata_d[7:0] = serial_pin_mode_q | SPM_FIXED_ONES;
            ADDR_POWER_MODE: rdata_d[2:0] = power_mode_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Alternate function routing
   always_comb begin
      alt_sel = '0;
      alt_oe = '0;
      alt_out = '0;
      alt_sel[PIN_SDOUT] = serial_pin_mode_q[SPM_DOUT_BIT];
      alt_oe[PIN_SDOUT] = 1'b1;
      alt_out[PIN_SDOUT] = serial_data_out;
      alt_sel[PIN_SDIN] = serial_pin_mode_q[SPM_DIN_BIT];
      alt_sel[PIN_SCLK] = serial_pin_mode_q[SPM_CLK_BIT];
      alt_oe[PIN_SCLK] = serial_clock_oe;
      alt_out[PIN_SCLK] = serial_clock_out;
   end

   assign serial_data_in = sync2_q[PIN_SDIN];
   assign serial_clock_in = sync2_q[PIN_SCLK];
   assign float_pins = (power_mode_q == EIOP2_MODE_STANDBY);
   assign hold_pins = (power_mode_q == EIOP2_MODE_SLEEP) || (power_mode_q == EIOP2_MODE_SUBSLEEP) ||
                      (power_mode_q == EIOP2_MODE_WATCH);

   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      eiop2_pin_cell u_cell (
         .aclk(aclk),
         .aresetn(aresetn),
         .alt_sel(alt_sel[i]),
         .alt_oe(alt_oe[i]),
         .alt_out(alt_out[i]),
         .alt_open_drain(serial_pin_mode_q[SPM_BUF_TYPE_BIT]),
         .dir_out(port_direction_q[i]),
         .latch_val(port_data_latch_q[i]),
         .open_drain(open_drain_select_q[i]),
         .float_pin(float_pins),
         .hold_pin(hold_pins),
         .pin_o(pin_o[i]),
         .pin_oe(pin_oe[i])
      );
   end
endmodule

// >>> eiop2_port_checker.sv
// Checker: pin drive and register reads of the 8-bit port, against bus writes
module eiop2_port_checker
   import eiop2_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [eiop2_pkg::ADDR_W+1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [eiop2_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [eiop2_pkg::ADDR_W+1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [eiop2_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [WIDTH-1:0] pin_o,
   input wire logic [WIDTH-1:0] pin_oe,
   input wire logic serial_data_out,
   input wire logic serial_clock_out,
   input wire logic serial_clock_oe
);
   logic [17:0] wa_q, ra_q;
   logic [7:0] wd_q, dir_q, lat_q, ods_q, spm_q;
   logic [2:0] pm_q;
   logic ws_q, bv_q;
   logic [37:0] cfg_q;
   wire logic [37:0] cfg = {dir_q, lat_q, ods_q, spm_q, pm_q, serial_data_out, serial_clock_out, serial_clock_oe};
   // Settings unchanged for a cycle and port awake
   wire logic act = cfg == cfg_q && pm_q < 3'h2;
   wire logic [7:0] gm = {5'h1F, ~spm_q[2:0]};
   always_ff @(posedge aclk) begin
      bv_q <= s_axi_bvalid;
      cfg_q <= cfg;
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[0];
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
      if (!aresetn) begin
         {dir_q, lat_q, ods_q, spm_q, pm_q} <= {24'h0, 8'hD8, 3'h0};
      end else if (s_axi_bvalid && !bv_q && ws_q) begin
         if (wa_q == ADDR_PORT_DIRECTION) dir_q <= wd_q;
         if (wa_q == ADDR_PORT_DATA_LATCH) lat_q <= wd_q;
         if (wa_q == ADDR_OPEN_DRAIN_SELECT) ods_q <= wd_q;
         if (wa_q == ADDR_SERIAL_PIN_MODE) spm_q <= wd_q | 8'hD8;
         if (wa_q == ADDR_POWER_MODE && wd_q[2:0] < 3'h6) pm_q <= wd_q[2:0];
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_of(logic [17:0] a);
      s_axi_rvalid && ra_q == a;
   endsequence
   reset_float_a: assert property ($rose(aresetn) |-> pin_oe == 8'h0) else $error("pin driven after reset");
   dir_ones_a: assert property (rd_of(ADDR_PORT_DIRECTION) |-> s_axi_rdata[7:0] == 8'hFF)
      else $error("direction read not all ones");
   spm_ones_a: assert property (rd_of(ADDR_SERIAL_PIN_MODE) |-> (s_axi_rdata[7:0] & 8'hD8) == 8'hD8)
      else $error("fixed mode bits not one");
   gen_dir_a: assert property (act |-> ((pin_oe ^ dir_q) & gm & ~ods_q) == 8'h0)
      else $error("general pin direction wrong");
   gen_level_a: assert property (act |-> ((pin_o ^ lat_q) & gm & dir_q & ~ods_q) == 8'h0)
      else $error("general pin level wrong");
   od_drive_a: assert property (act |-> ((pin_oe ^ (dir_q & ~lat_q)) & gm & ods_q) == 8'h0)
      else $error("open drain drive wrong");
   so_drive_a: assert property (act && spm_q[2] |-> pin_oe[2] == !(spm_q[5] && serial_data_out))
      else $error("serial out pin drive wrong");
   si_input_a: assert property (act && spm_q[1] |-> !pin_oe[1]) else $error("serial in pin driven");
   sck_drive_a: assert property (act && spm_q[0] |->
      pin_oe[0] == (serial_clock_oe && !(spm_q[5] && serial_clock_out))) else $error("serial clock pin drive wrong");
   standby_float_a: assert property (pm_q == 3'h5 |-> pin_oe == 8'h0) else $error("pin driven in standby");
   sleep_hold_a: assert property (pm_q inside {[2:4]} && $past(pm_q) inside {[2:4]} |->
      $stable(pin_o) && $stable(pin_oe)) else $error("pin changed while held");
endmodule

bind eiop2_port eiop2_port_checker #(.WIDTH(WIDTH)) u_eiop2_port_checker (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pin_o, .pin_oe,
   .serial_data_out, .serial_clock_out, .serial_clock_oe);

// >>> eiop2_pin_world.sv
// Board side of the port pins: external drivers, released lines toggle
module eiop2_pin_world
   import eiop2_pkg::*;
(
   input wire logic aclk,
   input wire logic [eiop2_pkg::PORT_W-1:0] pin_o,
   input wire logic [eiop2_pkg::PORT_W-1:0] pin_oe,
   input wire logic [eiop2_pkg::PORT_W-1:0] ext_val,
   input wire logic [eiop2_pkg::PORT_W-1:0] ext_oe,
   output logic [eiop2_pkg::PORT_W-1:0] pin_i
);
   logic flt_q = 1'b0;
   always_ff @(posedge aclk) flt_q <= !flt_q;
   always_comb begin
      for (int n = 0; n < PORT_W; n++) begin
         pin_i[n] = pin_oe[n] ? pin_o[n] : (ext_oe[n] ? ext_val[n] : flt_q);
      end
   end
endmodule

// >>> tb_eiop2_port.sv
// Self-checking bench for the 8-bit port over its register bus
module tb_eiop2_port
   import eiop2_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [17:0] SPM = ADDR_SERIAL_PIN_MODE, ODS = ADDR_OPEN_DRAIN_SELECT, LAT = ADDR_PORT_DATA_LATCH;
   localparam logic [17:0] DIR = ADDR_PORT_DIRECTION, PWR = ADDR_POWER_MODE;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic serial_data_out, serial_data_in, serial_clock_out, serial_clock_oe, serial_clock_in;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] pin_i, pin_o, pin_oe, ext_val, ext_oe;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   eiop2_port u_eiop2_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o,
      .pin_oe, .serial_data_out, .serial_data_in, .serial_clock_out, .serial_clock_oe, .serial_clock_in);
   eiop2_pin_world u_eiop2_pin_world (.aclk, .pin_o, .pin_oe, .ext_val, .ext_oe, .pin_i);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
      input logic [1:0] e = RESP_OKAY);
      logic aw, w, b;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk(32'(r), 32'(e));
   endtask
   task automatic rchk(input logic [17:0] a, input logic [7:0] e, input logic [1:0] re = RESP_OKAY);
      logic ar, v;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge aclk);
         ar = s_axi_arvalid && s_axi_arready;
         v = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk(d, {24'h0, e});
      chk(32'(r), 32'(re));
   endtask
   task automatic settle();
      repeat (4) @(negedge aclk);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {serial_data_out, serial_clock_out, serial_clock_oe} = '0;
      ext_val = 8'hA5;
      ext_oe = 8'hFF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(SPM, 8'hD8);
      rchk(ODS, 8'h00);
      rchk(DIR, 8'hFF);
      rchk(LAT, 8'hA5);
      chk(32'(pin_oe), 32'h0);
      wr(SPM, 8'h00);
      rchk(SPM, 8'hD8);
      wr(SPM, 8'h27);
      rchk(SPM, 8'hFF);
      wr(SPM, 8'h00);
      wr(DIR, 8'hF0);
      wr(LAT, 8'h3C);
      settle();
      chk(32'(pin_oe), 32'hF0);
      chk(32'(pin_o & 8'hF0), 32'h30);
      rchk(LAT, 8'h35);
      wr(ODS, 8'hF0);
      settle();
      chk(32'(pin_oe), 32'hC0);
      rchk(LAT, 8'h35);
      wr(ODS, 8'h00);
      wr(DIR, 8'hFF);
      ext_val <= 8'h02;
      serial_data_out <= 1'b1;
      serial_clock_oe <= 1'b1;
      wr(SPM, 8'h07);
      settle();
      chk(32'(pin_oe), 32'hFD);
      chk(32'(pin_o & 8'h04), 32'h04);
      chk(32'(serial_data_in), 32'h1);
      chk(32'(serial_clock_in), 32'h0);
      wr(SPM, 8'h27);
      settle();
      chk(32'(pin_oe), 32'hF9);
      serial_data_out <= 1'b0;
      settle();
      chk(32'(pin_oe), 32'hFD);
      chk(32'(pin_o & 8'h04), 32'h0);
      wr(SPM, 8'h00);
      wr(ODS, 8'h04);
      settle();
      chk(32'(pin_oe), 32'hFB);
      wr(PWR, 8'h02);
      wr(LAT, 8'hC3);
      for (int m = 2; m < 5; m++) begin
         wr(PWR, 8'(m));
         settle();
         chk(32'(pin_o & 8'hFB), 32'h38);
         chk(32'(pin_oe), 32'hFB);
      end
      wr(PWR, 8'h05);
      settle();
      chk(32'(pin_oe), 32'h0);
      wr(PWR, 8'h01);
      settle();
      chk(32'(pin_oe), 32'hFF);
      chk(32'(pin_o & 8'hFB), 32'hC3);
      wr(PWR, 8'h07);
      rchk(PWR, 8'h01);
      wr(PWR, 8'h00);
      wr(18'h0, 8'h55, 4'h1, RESP_SLVERR);
      rchk(18'h0, 8'h00, RESP_SLVERR);
      wr(ODS, 8'hFF, 4'h0);
      rchk(ODS, 8'h04);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(ODS, 8'h00);
      rchk(SPM, 8'hD8);
      chk(32'(pin_oe), 32'h0);
      wr(DIR, 8'hFF);
      rchk(LAT, 8'h00);
      results();
   end
endmodule
